// ---- dasr_map.svh ----
`ifndef DASR_MAP_SVH
`define DASR_MAP_SVH

// ****************************************************************
// word layout
// ****************************************************************
`define DASR_WORD_W 16
`define DASR_RES_W 12
`define DASR_BIT_ZERO 15
`define DASR_BIT_RANGE 14
`define DASR_BIT_CHAN 13
`define DASR_BIT_SRC 12
`define DASR_SRC_A 1'b0
`define DASR_SRC_B 1'b1

// ****************************************************************
// serial clock edge counts
// ****************************************************************
`define DASR_CNT_W 6
`define DASR_EDGES_WORD 6'h10
`define DASR_EDGES_EXT 6'h20
`define DASR_STREAM_LAST 6'h1F
`define DASR_TRACK_EDGES 6'h0D
`define DASR_PD_FIRST 6'h02
`define DASR_PD_LIMIT 6'h0A

// ****************************************************************
// reset values
// ****************************************************************
`define DASR_RST_BIT 1'b0
`define DASR_RST_CNT 6'h00

`endif

// ---- dasr_pkg.sv ----
`include "dasr_map.svh"

package dasr_pkg;

    // ****************************************************************
    // power modes
    // ****************************************************************
    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_PARTIAL = 2'b01,
        PWR_FULL = 2'b11
    } dasr_pwr_e;

    // ****************************************************************
    // carriers
    // ****************************************************************
    // pin levels captured when chip select falls
    typedef struct packed {
        logic range_sel;
        logic chan_a;
        logic chan_b;
    } dasr_status_s;

    // result pair from both converters
    typedef struct packed {
        logic [`DASR_RES_W-1:0] res_a;
        logic [`DASR_RES_W-1:0] res_b;
    } dasr_result_s;

    typedef logic [`DASR_WORD_W-1:0] dasr_word_t;
    typedef logic [2*`DASR_WORD_W-1:0] dasr_stream_t;
    typedef logic [`DASR_CNT_W-1:0] dasr_cnt_t;

endpackage : dasr_pkg

// ---- dasr_readout.sv ----
`timescale 1ns/1ps
`include "dasr_map.svh"


module dasr_readout (
    // system clock domain
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic CLK_EN,
    // serial link pins
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic RANGE_SEL,
    input wire logic CHAN_SEL_A,
    input wire logic CHAN_SEL_B,
    output logic SERIAL_OUT_FIRST,
    output logic SERIAL_OUT_FIRST_OE,
    output logic SERIAL_OUT_SECOND,
    output logic SERIAL_OUT_SECOND_OE,
    output logic SAMPLE_HOLD,
    // sample request towards the converter cores
    output logic SAMPLE_STROBE,
    output logic SAMPLE_RANGE,
    output logic SAMPLE_CHAN_A,
    output logic SAMPLE_CHAN_B,
    // results from the converter cores
    input wire logic [`DASR_RES_W-1:0] RESULT_A,
    input wire logic [`DASR_RES_W-1:0] RESULT_B,
    input wire logic RESULT_VALID,
    output logic RESULT_READY,
    // power state
    output logic [1:0] POWER_STATE
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // assemble one output word, status bits ahead of the result
    function automatic dasr_pkg::dasr_word_t make_word(
        input logic range_sel,
        input logic chan,
        input logic src,
        input logic [`DASR_RES_W-1:0] res
    );
        dasr_pkg::dasr_word_t w;
        w = '0;
        w[`DASR_BIT_ZERO] = 1'b0;
        w[`DASR_BIT_RANGE] = range_sel;
        w[`DASR_BIT_CHAN] = chan;
        w[`DASR_BIT_SRC] = src;
        w[`DASR_RES_W-1:0] = res;
        return w;
    endfunction : make_word

    // bit launched after a given number of falling edges
    function automatic logic pick(
        input dasr_pkg::dasr_stream_t s,
        input dasr_pkg::dasr_cnt_t idx
    );
        dasr_pkg::dasr_cnt_t pos;
        pos = `DASR_STREAM_LAST - idx;
        return s[pos[4:0]];
    endfunction : pick

    // ****************************************************************
    // link reset
    // ****************************************************************
    // chip select high holds every serial clock register of the link side cleared
    logic link_rst_n;
    assign link_rst_n = NRST & ~CS_N;

    // ****************************************************************
    // capture at chip select fall
    // ****************************************************************
    dasr_pkg::dasr_status_s cap;

    // pins are sampled on the very edge that starts the conversion
    always_ff @(negedge CS_N or negedge NRST) begin
        if (!NRST) begin
            cap <= '0;
        end else begin
            cap <= '{RANGE_SEL, CHAN_SEL_A, CHAN_SEL_B};
        end
    end

    // ****************************************************************
    // falling edge counter
    // ****************************************************************
    dasr_pkg::dasr_cnt_t fall_cnt;
    dasr_pkg::dasr_cnt_t next_fall_cnt;

    // saturate at the end of the extended read
    always_comb begin
        if (fall_cnt == `DASR_EDGES_EXT) begin
            next_fall_cnt = fall_cnt;
        end else begin
            next_fall_cnt = fall_cnt + 6'h01;
        end
    end

    // counter restarts with every frame through the link reset
    always_ff @(negedge SCLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fall_cnt <= `DASR_RST_CNT;
        end else begin
            fall_cnt <= next_fall_cnt;
        end
    end

    // ****************************************************************
    // result crossing into the link domain
    // ****************************************************************
    dasr_pkg::dasr_result_s result_hold;
    logic result_held;
    logic held_meta;
    logic held_sync;
    logic got;
    dasr_pkg::dasr_result_s res;

    // two-flop sync of the held flag on the serial clock
    always_ff @(negedge SCLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            held_meta <= `DASR_RST_BIT;
            held_sync <= `DASR_RST_BIT;
        end else begin
            held_meta <= result_held;
            held_sync <= held_meta;
        end
    end

    // hold words stay frozen while held, so a single copy is safe
    always_ff @(negedge SCLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            got <= `DASR_RST_BIT;
            res <= '0;
        end else if (held_sync && !got) begin
            got <= 1'b1;
            res <= result_hold;
        end
    end

    // ****************************************************************
    // output streams
    // ****************************************************************
    dasr_pkg::dasr_word_t word_a;
    dasr_pkg::dasr_word_t word_b;
    dasr_pkg::dasr_stream_t stream_first;
    dasr_pkg::dasr_stream_t stream_second;

    // each line carries its own word, then the other one
    always_comb begin
        word_a = make_word(cap.range_sel, cap.chan_a, `DASR_SRC_A,
            res.res_a);
        word_b = make_word(cap.range_sel, cap.chan_b, `DASR_SRC_B,
            res.res_b);
        stream_first = {word_a, word_b};
        stream_second = {word_b, word_a};
    end

    // ****************************************************************
    // data launch on falling edges
    // ****************************************************************
    logic dout_first;
    logic dout_second;

    // reset value is the leading zero seen right at select fall
    always_ff @(negedge SCLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            dout_first <= `DASR_RST_BIT;
            dout_second <= `DASR_RST_BIT;
        end else if (next_fall_cnt <= `DASR_STREAM_LAST) begin
            dout_first <= pick(stream_first, next_fall_cnt);
            dout_second <= pick(stream_second, next_fall_cnt);
        end
    end

    assign SERIAL_OUT_FIRST = dout_first;
    assign SERIAL_OUT_SECOND = dout_second;

    // ****************************************************************
    // rising edge controls
    // ****************************************************************
    logic done;
    logic track;

    // release after the 32nd rise; track after the 13th fall
    always_ff @(posedge SCLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            done <= `DASR_RST_BIT;
            track <= `DASR_RST_BIT;
        end else begin
            if (fall_cnt == `DASR_EDGES_EXT) begin
                done <= 1'b1;
            end
            if (fall_cnt >= `DASR_TRACK_EDGES) begin
                track <= 1'b1;
            end
        end
    end

    // enables must move on select itself, no clock edge is available
    assign SERIAL_OUT_FIRST_OE = link_rst_n & ~done;
    assign SERIAL_OUT_SECOND_OE = link_rst_n & ~done;
    assign SAMPLE_HOLD = link_rst_n & ~track;

    // ****************************************************************
    // power mode, stepped on a chip select rise after 2 to 9 falls
    // ****************************************************************
    dasr_pkg::dasr_pwr_e pwr;

    // fall_cnt is read before the link reset clears it on this edge
    always_ff @(posedge CS_N or negedge NRST) begin
        if (!NRST) begin
            pwr <= dasr_pkg::PWR_NORMAL;
        end else if (fall_cnt >= `DASR_PD_LIMIT) begin
            pwr <= dasr_pkg::PWR_NORMAL;
        end else if (fall_cnt >= `DASR_PD_FIRST) begin
            unique case (pwr)
                dasr_pkg::PWR_NORMAL: begin
                    pwr <= dasr_pkg::PWR_PARTIAL;
                end
                dasr_pkg::PWR_PARTIAL: begin
                    pwr <= dasr_pkg::PWR_FULL;
                end
                dasr_pkg::PWR_FULL: begin
                    pwr <= dasr_pkg::PWR_FULL;
                end
            endcase
        end
    end

    // ****************************************************************
    // system side: select edge detect
    // ****************************************************************
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;

    // two flops before any logic looks at chip select
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else if (CLK_EN) begin
            cs_meta <= CS_N;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    // one-cycle sample request; captured pins are settled by now
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            SAMPLE_STROBE <= `DASR_RST_BIT;
            SAMPLE_RANGE <= `DASR_RST_BIT;
            SAMPLE_CHAN_A <= `DASR_RST_BIT;
            SAMPLE_CHAN_B <= `DASR_RST_BIT;
        end else if (CLK_EN) begin
            SAMPLE_STROBE <= cs_prev & ~cs_sync;
            if (cs_prev && !cs_sync) begin
                SAMPLE_RANGE <= cap.range_sel;
                SAMPLE_CHAN_A <= cap.chan_a;
                SAMPLE_CHAN_B <= cap.chan_b;
            end
        end
    end

    // ****************************************************************
    // system side: result hold
    // ****************************************************************
    logic fall_seen;
    assign fall_seen = cs_prev & ~cs_sync;

    // one result pair per frame; a new sample reopens the slot
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            RESULT_READY <= `DASR_RST_BIT;
            result_held <= `DASR_RST_BIT;
            result_hold <= '0;
        end else if (CLK_EN) begin
            if (RESULT_READY && RESULT_VALID) begin
                result_hold <= '{RESULT_A, RESULT_B};
                result_held <= 1'b1;
            end else if (fall_seen) begin
                result_held <= 1'b0;
            end
            if (fall_seen) begin
                RESULT_READY <= 1'b1;
            end else if (RESULT_VALID) begin
                RESULT_READY <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // system side: power state report
    // ****************************************************************
    logic [1:0] pwr_meta;
    logic [1:0] pwr_sync;
    logic [1:0] pwr_prev;

    // two codes may change at once, so take only a steady value
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            pwr_meta <= dasr_pkg::PWR_NORMAL;
            pwr_sync <= dasr_pkg::PWR_NORMAL;
            pwr_prev <= dasr_pkg::PWR_NORMAL;
            POWER_STATE <= dasr_pkg::PWR_NORMAL;
        end else if (CLK_EN) begin
            pwr_meta <= pwr;
            pwr_sync <= pwr_meta;
            pwr_prev <= pwr_sync;
            if (pwr_sync == pwr_prev) begin
                POWER_STATE <= pwr_prev;
            end
        end
    end

endmodule : dasr_readout

// ---- dasr_readout_checker.sv ----
`timescale 1ns/1ps
`include "dasr_map.svh"

module dasr_readout_checker (
    // clocks and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic SCLK,
    // serial link
    input wire logic CS_N,
    input wire logic SERIAL_OUT_FIRST_OE,
    input wire logic SERIAL_OUT_SECOND_OE,
    input wire logic SAMPLE_HOLD,
    // converter handshake and power
    input wire logic SAMPLE_STROBE,
    input wire logic RESULT_VALID,
    input wire logic RESULT_READY,
    input wire logic [1:0] POWER_STATE
);
    logic [5:0] fall_cnt;
    logic past_last;

    // ****************
    // frame helpers
    // ****************
    // select high clears the count, as it clears the link logic
    always_ff @(negedge SCLK or posedge CS_N or negedge NRST) begin
        if (!NRST || CS_N) fall_cnt <= 6'h00;
        else if (fall_cnt != 6'h3F) fall_cnt <= fall_cnt + 6'h01;
    end

    // marks the rise after the last fall of a double word
    always_ff @(posedge SCLK or posedge CS_N or negedge NRST) begin
        if (!NRST || CS_N) past_last <= 1'b0;
        else if (fall_cnt == `DASR_EDGES_EXT) past_last <= 1'b1;
    end

    sequence s_frame_start;
        $fell(CS_N);
    endsequence

    sequence s_strobe_seen;
        ##[1:6] SAMPLE_STROBE;
    endsequence

    // ****************
    // assertions
    // ****************
    a_idle_released:
    assert property (@(posedge REF_CLK) disable iff (!NRST)
        CS_N |-> !SERIAL_OUT_FIRST_OE && !SERIAL_OUT_SECOND_OE)
        else $error("data line driven while deselected");
    a_idle_tracking:
    assert property (@(posedge REF_CLK) disable iff (!NRST)
        CS_N |-> !SAMPLE_HOLD) else $error("hold while deselected");
    a_strobe_single:
    assert property (@(posedge REF_CLK) disable iff (!NRST)
        SAMPLE_STROBE |=> !SAMPLE_STROBE) else $error("strobe too long");
    a_strobe_follows:
    assert property (@(posedge REF_CLK) disable iff (!NRST)
        s_frame_start |-> s_strobe_seen) else $error("no sample strobe");
    a_result_taken:
    assert property (@(posedge REF_CLK) disable iff (!NRST)
        RESULT_READY && RESULT_VALID |=> !RESULT_READY || SAMPLE_STROBE)
        else $error("ready stayed after result");
    a_power_no_jump:
    assert property (@(posedge REF_CLK) disable iff (!NRST)
        POWER_STATE != 2'b10 &&
        !(POWER_STATE == 2'b11 && $past(POWER_STATE) == 2'b00))
        else $error("illegal power step");
    a_track_late:
    assert property (@(posedge REF_CLK) disable iff (!NRST)
        !CS_N && fall_cnt >= 6'h0E |-> !SAMPLE_HOLD)
        else $error("still holding after fall 13");
    a_hold_early:
    assert property (@(posedge SCLK) disable iff (!NRST)
        !CS_N && fall_cnt <= `DASR_TRACK_EDGES
        |-> SAMPLE_HOLD) else $error("tracking too early");
    a_drive_frame:
    assert property (@(posedge SCLK) disable iff (!NRST)
        !CS_N && fall_cnt != 6'h00 && fall_cnt < `DASR_EDGES_EXT
        |-> SERIAL_OUT_FIRST_OE && SERIAL_OUT_SECOND_OE)
        else $error("line released inside frame");
    a_release_last:
    assert property (@(posedge REF_CLK) disable iff (!NRST)
        past_last |-> !SERIAL_OUT_FIRST_OE && !SERIAL_OUT_SECOND_OE)
        else $error("line driven after rise 32");
endmodule : dasr_readout_checker

bind dasr_readout dasr_readout_checker dasr_readout_checker_inst (
    .REF_CLK(REF_CLK), .NRST(NRST), .SCLK(SCLK), .CS_N(CS_N),
    .SERIAL_OUT_FIRST_OE(SERIAL_OUT_FIRST_OE),
    .SERIAL_OUT_SECOND_OE(SERIAL_OUT_SECOND_OE),
    .SAMPLE_HOLD(SAMPLE_HOLD), .SAMPLE_STROBE(SAMPLE_STROBE),
    .RESULT_VALID(RESULT_VALID), .RESULT_READY(RESULT_READY),
    .POWER_STATE(POWER_STATE));

// ---- dasr_host_port.sv ----
`timescale 1ns/1ps

module dasr_host_port (
    // pins driven by the host
    output logic SCLK,
    output logic CS_N,
    // data lines from the device
    input wire logic D_FIRST,
    input wire logic OE_FIRST,
    input wire logic D_SECOND,
    input wire logic OE_SECOND
);
    // a released line shows the inverse of its last bit, never a stale
    // copy, so an early release cannot pass for good data
    wire line_a = OE_FIRST ? D_FIRST : ~D_FIRST;
    wire line_b = OE_SECOND ? D_SECOND : ~D_SECOND;

    initial begin
        SCLK = 1'b1;
        CS_N = 1'b1;
    end

    // clock stands still outside frames; sampled on falls, though a
    // slow host could take each bit on the rise instead
    task automatic frame(input int n, output logic [31:0] wa,
            output logic [31:0] wb);
        wa = '0;
        wb = '0;
        #3 CS_N = 1'b0;
        #200;
        for (int k = 0; k < n; k++) begin
            wa = {wa[30:0], line_a};
            wb = {wb[30:0], line_b};
            SCLK = 1'b0;
            #40 SCLK = 1'b1;
            #40;
        end
        CS_N = 1'b1;
        #300;
    endtask : frame
endmodule : dasr_host_port

// ---- test_dasr_readout.sv ----
`timescale 1ns/1ps
`include "dasr_map.svh"

module test_dasr_readout;
    logic ref_clk, nrst, sclk, cs_n, range_sel, chan_a, chan_b;
    logic out_a, oe_a, out_b, oe_b, hold, strobe, s_rng, s_ca, s_cb;
    logic valid, ready;
    logic [1:0] power;
    logic [`DASR_RES_W-1:0] res_a, res_b;
    logic [31:0] wa, wb;
    logic [15:0] xa, xb;
    int n_errors, n_tests;

    // ****************
    // design and host
    // ****************
    dasr_readout dasr_readout_inst (
        .REF_CLK(ref_clk), .NRST(nrst), .CLK_EN(1'b1), .SCLK(sclk),
        .CS_N(cs_n), .RANGE_SEL(range_sel), .CHAN_SEL_A(chan_a),
        .CHAN_SEL_B(chan_b), .SERIAL_OUT_FIRST(out_a),
        .SERIAL_OUT_FIRST_OE(oe_a), .SERIAL_OUT_SECOND(out_b),
        .SERIAL_OUT_SECOND_OE(oe_b), .SAMPLE_HOLD(hold),
        .SAMPLE_STROBE(strobe), .SAMPLE_RANGE(s_rng),
        .SAMPLE_CHAN_A(s_ca), .SAMPLE_CHAN_B(s_cb), .RESULT_A(res_a),
        .RESULT_B(res_b), .RESULT_VALID(valid), .RESULT_READY(ready),
        .POWER_STATE(power));
    dasr_host_port host_inst (.SCLK(sclk), .CS_N(cs_n), .D_FIRST(out_a),
        .OE_FIRST(oe_a), .D_SECOND(out_b), .OE_SECOND(oe_b));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // converter cores answer as soon as they are asked
    always @(posedge ref_clk) begin
        #1;
        valid = ready & ~valid;
    end

    // ****************
    // helpers
    // ****************
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] word(input logic src, input logic ch,
            input logic [11:0] res);
        return {1'b0, range_sel, ch, src, res};
    endfunction : word

    task automatic setup(input logic [2:0] pins, input logic [11:0] ra);
        @(posedge ref_clk);
        #1;
        {range_sel, chan_a, chan_b} = pins;
        res_a = ra;
        res_b = ~ra;
        xa = word(`DASR_SRC_A, chan_a, res_a);
        xb = word(`DASR_SRC_B, chan_b, res_b);
    endtask : setup

    task automatic do_reset;
        @(posedge ref_clk);
        #1 nrst = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask : do_reset

    // ****************
    // scenarios
    // ****************
    task automatic t_single;
        for (int i = 0; i < 8; i++) begin
            setup(i[2:0], 12'hF0F ^ {4{i[2:0]}});
            host_inst.frame(16, wa, wb);
            check("first word", wa, {16'h0000, xa});
            check("second word", wb, {16'h0000, xb});
            check("pins", {s_rng, s_ca, s_cb}, i[2:0]);
        end
        $display("single words done");
    endtask : t_single

    task automatic t_double;
        setup(3'h5, 12'h801);
        host_inst.frame(32, wa, wb);
        check("first pair", wa, {xa, xb});
        check("second pair", wb, {xb, xa});
        $display("double words done");
    endtask : t_double

    task automatic t_abort;
        setup(3'h2, 12'hC33);
        host_inst.frame(12, wa, wb);
        check("cut word", wa, {20'h00000, xa[15:4]});
        setup(3'h4, 12'h5A5);
        host_inst.frame(16, wa, wb);
        check("word after cut", wb, {16'h0000, xb});
        check("power after cut", power, 2'b00);
        $display("abort done");
    endtask : t_abort

    task automatic t_power;
        int n_fall[5] = '{5, 5, 1, 10, 2};
        logic [1:0] mode[5] = '{dasr_pkg::PWR_PARTIAL, dasr_pkg::PWR_FULL,
            dasr_pkg::PWR_FULL, dasr_pkg::PWR_NORMAL, dasr_pkg::PWR_PARTIAL};
        for (int i = 0; i < 5; i++) begin
            host_inst.frame(n_fall[i], wa, wb);
            check("power state", power, mode[i]);
        end
        do_reset;
        check("power after reset", power, 2'b00);
        check("ready after reset", ready, 1'b0);
        $display("power modes done");
    endtask : t_power

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // a hang counts as a mismatch
    initial begin
        #1000000;
        n_errors++;
        tally_and_finish;
    end

    initial begin
        nrst = 1'b0;
        {range_sel, chan_a, chan_b} = 3'h0;
        res_a = '0;
        res_b = '0;
        n_errors = 0;
        n_tests = 0;
        do_reset;
        t_single;
        t_double;
        t_abort;
        t_power;
        tally_and_finish;
    end
endmodule : test_dasr_readout
